// >>> hw/sfc_pkg.sv
/*
  Package for the serial flash setting-command decoder: opcodes, register
  reset values, mode codes and the Wishbone register map.
  Assumes a 100 MHz system clock and a slower serial clock sampled by it.
*/
package sfc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Opcodes
  localparam logic [7:0] OP_SET_WRITE_LATCH   = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_READ       = 8'h05;
  localparam logic [7:0] OP_CONFIG_READ       = 8'h15;
  localparam logic [7:0] OP_STATUS_CFG_WRITE  = 8'h01;
  localparam logic [7:0] OP_EXT_ADDR_READ     = 8'hc8;
  localparam logic [7:0] OP_EXT_ADDR_WRITE    = 8'hc5;
  localparam logic [7:0] OP_PROTECT_SELECT    = 8'h68;
  localparam logic [7:0] OP_QUAD_ENTER        = 8'h35;
  localparam logic [7:0] OP_QUAD_EXIT         = 8'hf5;
  localparam logic [7:0] OP_WIDE_ENTER        = 8'hb7;
  localparam logic [7:0] OP_WIDE_EXIT         = 8'he9;
  localparam logic [7:0] OP_SUSPEND_A         = 8'hb0;
  localparam logic [7:0] OP_SUSPEND_B         = 8'h75;
  localparam logic [7:0] OP_RESUME_A          = 8'h30;
  localparam logic [7:0] OP_RESUME_B          = 8'h7a;
  localparam logic [7:0] OP_SLEEP_ENTER       = 8'hb9;
  localparam logic [7:0] OP_SLEEP_RELEASE     = 8'hab;
  localparam logic [7:0] OP_BURST_LENGTH      = 8'hc0;
  localparam logic [7:0] OP_BOOT_READ         = 8'h16;
  localparam logic [7:0] OP_BOOT_WRITE        = 8'h17;
  localparam logic [7:0] OP_BOOT_ERASE        = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counts
  localparam logic [7:0]  STATUS_RST    = 8'h00;
  localparam logic [7:0]  CONFIG_RST    = 8'h00;
  localparam logic [7:0]  EXT_ADDR_RST  = 8'h00;
  localparam logic [7:0]  BURST_RST     = 8'h00;
  localparam logic [31:0] BOOT_RST      = 32'hffff_ffff;
  localparam logic [2:0]  BOOT_BYTES    = 3'h4;
  localparam int          STATUS_LATCH_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone register map (byte addresses)
  localparam logic [7:0] REG_STATE    = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_CONFIG   = 8'h08;
  localparam logic [7:0] REG_EXT_ADDR = 8'h0c;
  localparam logic [7:0] REG_BURST    = 8'h10;
  localparam logic [7:0] REG_BOOT     = 8'h14;
  localparam logic [7:0] REG_EVENTS   = 8'h18;

  // Bit positions inside REG_STATE
  localparam int ST_LATCH   = 0;
  localparam int ST_QUAD    = 1;
  localparam int ST_WIDE    = 2;
  localparam int ST_PROTECT = 3;
  localparam int ST_SUSPEND = 4;
  localparam int ST_SLEEP   = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine states
  typedef enum logic [3:0] {
    SFC_IDLE = 4'b0001,
    SFC_OPC  = 4'b0010,
    SFC_DATA = 4'b0100,
    SFC_SKIP = 4'b1000
  } sfc_state_t;

  // Serial pins as seen by the device
  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic [3:0] dq;
  } sfc_pins_t;

endpackage : sfc_pkg

// >>> hw/sfc_decoder.sv
/*
  Setting-command decoder of a serial multi-line flash device. Samples the
  host's chip select, serial clock and data lines with the 100 MHz clock,
  decodes register/setting opcodes, shifts read data out and exposes the
  resulting state over a classic Wishbone slave.
  Assumes the serial clock is at most a quarter of clk_i; mode 0 timing
  (data sampled on rising sclk, driven after falling sclk).
*/
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
module sfc_decoder (
  // System
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Serial pins from the host
  input  wire sfc_pkg::sfc_pins_t  pins_i,
  output logic [3:0]               dq_o,
  output logic [3:0]               dq_oe_n_o,
  // Status for the array engine
  output logic                     addr_four_bytes_o,
  output logic                     suspend_req_o,
  output logic                     resume_req_o,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o
);
  import sfc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops before anything reads a pin
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  logic       sclk_d_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff  <= 6'h01;
      sync2_ff  <= 6'h01;
      sclk_d_ff <= 1'b0;
    end else begin
      sync1_ff  <= {pins_i.dq, pins_i.sclk, pins_i.cs_n};
      sync2_ff  <= sync1_ff;
      sclk_d_ff <= sync2_ff[1];
    end
  end

  logic       cs_n;
  logic [3:0] dq_in;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_n_d_ff;
  assign cs_n      = sync2_ff[0];
  assign dq_in     = sync2_ff[5:2];
  assign sclk_rise = ~cs_n & sync2_ff[1] & ~sclk_d_ff;
  assign sclk_fall = ~cs_n & ~sync2_ff[1] & sclk_d_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) cs_n_d_ff <= 1'b1;
    else       cs_n_d_ff <= cs_n;
  end

  logic frame_start;
  logic frame_end;
  assign frame_start = cs_n_d_ff & ~cs_n;
  assign frame_end   = ~cs_n_d_ff & cs_n;

  ////////////////////////////////////////////////////////////////////////////
  // Device state
  logic        write_latch_ff;
  logic        quad_ff;
  logic        wide_ff;
  logic        protect_ff;
  logic        suspend_ff;
  logic        sleep_ff;
  logic [7:0]  status_ff;
  logic [7:0]  config_ff;
  logic [7:0]  ext_addr_ff;
  logic [7:0]  burst_ff;
  logic [31:0] boot_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Byte assembly: 8 edges single-line, 2 edges four-line
  sfc_state_t  state_ff;
  logic [7:0]  shift_ff;
  logic [2:0]  bitcnt_ff;
  logic [7:0]  opcode_ff;
  logic [2:0]  nbytes_ff;
  logic [31:0] data_ff;
  logic        quad_frame_ff;    // Mode latched at frame start
  logic [7:0]  nxt_shift;
  logic        byte_done;
  assign nxt_shift = quad_frame_ff ? {shift_ff[3:0], dq_in} : {shift_ff[6:0], dq_in[0]};
  assign byte_done = sclk_rise & (quad_frame_ff ? (bitcnt_ff == 3'h1) : (bitcnt_ff == 3'h7));

  // Opcode legality in the current mode; illegal frames are swallowed
  function automatic logic op_legal(input logic [7:0] op, input logic quad, input logic sleep);
    logic ok;
    ok = 1'b1;
    if (sleep)
      ok = (op == OP_SLEEP_RELEASE);
    else if (op == OP_PROTECT_SELECT || op == OP_QUAD_ENTER ||
             op == OP_BOOT_READ || op == OP_BOOT_WRITE || op == OP_BOOT_ERASE)
      ok = ~quad;
    else if (op == OP_QUAD_EXIT)
      ok = quad;
    return ok;
  endfunction : op_legal

  // Frame sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff      <= SFC_IDLE;
      shift_ff      <= 8'h00;
      bitcnt_ff     <= 3'h0;
      opcode_ff     <= 8'h00;
      nbytes_ff     <= 3'h0;
      data_ff       <= 32'h0;
      quad_frame_ff <= 1'b0;
    end else if (cs_n) begin
      state_ff  <= SFC_IDLE;
      bitcnt_ff <= 3'h0;
    end else begin
      if (frame_start) begin
        state_ff      <= SFC_OPC;
        quad_frame_ff <= quad_ff;
        nbytes_ff     <= 3'h0;
        bitcnt_ff     <= 3'h0;
      end
      if (sclk_rise) begin
        shift_ff  <= nxt_shift;
        bitcnt_ff <= byte_done ? 3'h0 : bitcnt_ff + 3'h1;
      end
      if (byte_done) begin
        case (state_ff)
          SFC_OPC: begin
            opcode_ff <= nxt_shift;
            state_ff  <= op_legal(nxt_shift, quad_frame_ff, sleep_ff) ? SFC_DATA : SFC_SKIP;
          end
          SFC_DATA: begin
            if (nbytes_ff != BOOT_BYTES) begin
              data_ff   <= {data_ff[23:0], nxt_shift};
              nbytes_ff <= nbytes_ff + 3'h1;
            end
          end
          default: state_ff <= state_ff;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commit at chip-select rise
  logic commit;
  assign commit = frame_end & (state_ff == SFC_DATA);

  // Mode and flag state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_latch_ff <= 1'b0;
      quad_ff    <= 1'b0;
      wide_ff    <= 1'b0;
      protect_ff <= 1'b0;
      suspend_ff <= 1'b0;
      sleep_ff   <= 1'b0;
    end else if (commit) begin
      case (opcode_ff)
        OP_SET_WRITE_LATCH:   write_latch_ff <= 1'b1;
        OP_CLEAR_WRITE_LATCH: write_latch_ff <= 1'b0;
        OP_PROTECT_SELECT:    protect_ff <= write_latch_ff;
        OP_QUAD_ENTER:        quad_ff    <= 1'b1;
        OP_QUAD_EXIT:         quad_ff    <= 1'b0;
        OP_WIDE_ENTER:        wide_ff    <= 1'b1;
        OP_WIDE_EXIT:         wide_ff    <= 1'b0;
        OP_SUSPEND_A,
        OP_SUSPEND_B:         suspend_ff <= 1'b1;
        OP_RESUME_A,
        OP_RESUME_B:          suspend_ff <= 1'b0;
        OP_SLEEP_ENTER:       sleep_ff   <= 1'b1;
        OP_SLEEP_RELEASE:     sleep_ff   <= 1'b0;
        OP_STATUS_CFG_WRITE,
        OP_EXT_ADDR_WRITE,
        OP_BOOT_WRITE,
        OP_BOOT_ERASE:        write_latch_ff <= 1'b0;  // All writes but burst length consume the latch
        default:              write_latch_ff <= write_latch_ff;
      endcase
    end
  end

  // Data registers; status, config and boot writes need the latch, ext-address and burst writes only the byte count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_ff   <= STATUS_RST;
      config_ff   <= CONFIG_RST;
      ext_addr_ff <= EXT_ADDR_RST;
      burst_ff    <= BURST_RST;
      boot_ff     <= BOOT_RST;
    end else if (commit) begin
      case (opcode_ff)
        OP_STATUS_CFG_WRITE: begin
          if (write_latch_ff && nbytes_ff == 3'h1) begin
            status_ff <= data_ff[7:0];
          end else if (write_latch_ff && nbytes_ff >= 3'h2) begin
            status_ff <= data_ff[15:8];
            config_ff <= data_ff[7:0];
          end
        end
        OP_EXT_ADDR_WRITE: begin
          if (nbytes_ff == 3'h1) ext_addr_ff <= data_ff[7:0];
        end
        OP_BURST_LENGTH: begin
          if (nbytes_ff != 3'h0) burst_ff <= data_ff[7:0];
        end
        OP_BOOT_WRITE: begin
          if (write_latch_ff && nbytes_ff == BOOT_BYTES) boot_ff <= data_ff;
        end
        OP_BOOT_ERASE: begin
          if (write_latch_ff) boot_ff <= BOOT_RST;
        end
        default: boot_ff <= boot_ff;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-data shifter, driven after falling sclk once the opcode is in
  logic [7:0] rd_byte;
  logic       is_read;
  logic [7:0] live_status;
  assign live_status = {status_ff[7:STATUS_LATCH_BIT+1], write_latch_ff, status_ff[0]};
  always_comb begin
    is_read = 1'b1;
    rd_byte = 8'h00;
    case (opcode_ff)
      OP_STATUS_READ:   rd_byte = live_status;
      OP_CONFIG_READ:   rd_byte = config_ff;
      OP_EXT_ADDR_READ: rd_byte = ext_addr_ff;
      OP_BOOT_READ:     rd_byte = boot_ff[8*(3-nbytes_ff[1:0]) +: 8];
      default:          is_read = 1'b0;
    endcase
  end

  logic [7:0] out_ff;
  logic       drive_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i || cs_n) begin
      out_ff   <= 8'h00;
      drive_ff <= 1'b0;
    end else if (sclk_fall && state_ff == SFC_DATA && is_read) begin
      drive_ff <= 1'b1;
      if (bitcnt_ff == 3'h0) out_ff <= rd_byte;   // New byte at each boundary
      else                   out_ff <= quad_frame_ff ? {out_ff[3:0], 4'h0} : {out_ff[6:0], 1'b0};
    end
  end

  // Single-line mode answers on line 1; four-line mode on all lines
  assign dq_o      = quad_frame_ff ? out_ff[7:4] : {2'b00, out_ff[7], 1'b0};
  assign dq_oe_n_o = ~drive_ff ? 4'hf : (quad_frame_ff ? 4'h0 : 4'hd);

  assign addr_four_bytes_o = wide_ff;
  assign suspend_req_o     = suspend_ff;
  assign resume_req_o      = ~suspend_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, ack drops the cycle after
  logic [31:0] wb_rd;
  always_comb begin
    if (wb_adr_i == REG_STATE)
      wb_rd = {26'h0, sleep_ff, suspend_ff, protect_ff, wide_ff, quad_ff, write_latch_ff};
    else if (wb_adr_i == REG_STATUS)   wb_rd = {24'h0, live_status};
    else if (wb_adr_i == REG_CONFIG)   wb_rd = {24'h0, config_ff};
    else if (wb_adr_i == REG_EXT_ADDR) wb_rd = {24'h0, ext_addr_ff};
    else if (wb_adr_i == REG_BURST)    wb_rd = {24'h0, burst_ff};
    else if (wb_adr_i == REG_BOOT)     wb_rd = boot_ff;
    else if (wb_adr_i == REG_EVENTS)   wb_rd = {24'h0, opcode_ff};
    else                               wb_rd = 32'h0;
  end

  // Registers are read-only from the bus; writes are acknowledged and dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) wb_dat_o <= wb_rd;
    end
  end

endmodule : sfc_decoder

// >>> tb/sfc_decoder_asserts.sv
/*
  Port checker for the setting-command decoder.
  Assumes a bind onto every decoder instance and one clock domain.
*/
`timescale 1ns/1ns
module sfc_decoder_asserts (
  // System
  input wire logic               clk_i,
  input wire logic               rst_i,
  // Serial side
  input wire sfc_pkg::sfc_pins_t pins_i,
  input wire logic [3:0]         dq_oe_n_o,
  input wire logic               addr_four_bytes_o,
  input wire logic               suspend_req_o,
  input wire logic               resume_req_o,
  // Wishbone
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_ack_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: one cycle after the request, one cycle wide
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered after one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");

  ////////////////////////////////////////////////////////////////////////////
  // Serial side: drivers released when deselected, flags move at frame end
  resume_inv_a: assert property (resume_req_o == !suspend_req_o)
    else $error("resume is not the inverse of suspend");
  oe_idle_a: assert property (pins_i.cs_n [*5] |-> dq_oe_n_o == 4'hf)
    else $error("data line driven while deselected");
  oe_code_a: assert property (dq_oe_n_o inside {4'hf, 4'hd, 4'h0})
    else $error("illegal output enable pattern");
  oe_start_a: assert property ($fell(dq_oe_n_o[1]) |-> !pins_i.cs_n)
    else $error("read data started outside a frame");
  wide_end_a: assert property ($changed(addr_four_bytes_o) |->
    $past(pins_i.cs_n, 2) && pins_i.cs_n)
    else $error("address width changed inside a frame");
  suspend_end_a: assert property ($changed(suspend_req_o) |->
    $past(pins_i.cs_n, 2) && pins_i.cs_n)
    else $error("suspend changed inside a frame");
endmodule : sfc_decoder_asserts

bind sfc_decoder sfc_decoder_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .pins_i(pins_i), .dq_oe_n_o(dq_oe_n_o),
  .addr_four_bytes_o(addr_four_bytes_o), .suspend_req_o(suspend_req_o),
  .resume_req_o(resume_req_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o)
);

// >>> tb/sfc_host_model.sv
/*
  Host flash controller model: drives select, serial clock and data lines.
  Assumes the bench resolves shared data lines from the device's enables.
*/
`timescale 1ns/1ns
module sfc_host_model (
  // Pins toward the device
  output sfc_pkg::sfc_pins_t pins_o,
  // Resolved data lines
  input  wire logic [3:0]    dq_i
);
  import sfc_pkg::*;

  // Idle: deselected, clock parked low
  initial pins_o = '{cs_n: 1'b1, sclk: 1'b0, dq: 4'h0};

  ////////////////////////////////////////////////////////////////////////////
  // One frame, 125 ns serial clock: opcode, nd bytes out, nr bytes in
  task automatic frame(input bit q, input logic [7:0] op, input int nd,
                       input logic [31:0] d, input int nr, output logic [31:0] rx);
    logic [39:0] tx;
    int          w;
    int          k;
    tx = {op, d << (8 * (4 - nd))};
    w  = q ? 4 : 1;
    rx = 32'h0;
    // Step off the system clock edge so no pin moves as it is sampled
    #1;
    pins_o.cs_n = 1'b0;
    // Opcode first, MSB first; spare lines toggle so no stale level sticks
    for (k = 0; k < 8 * (nd + 1); k += w) begin
      pins_o.dq = q ? tx[39 - k -: 4] : {{3{k[0]}}, tx[39 - k]};
      #62 pins_o.sclk = 1'b1;
      #63 pins_o.sclk = 1'b0;
    end
    // Read phase: our drive is overridden wherever the device enables
    for (k = 0; k < 8 * nr; k += w) begin
      pins_o.dq = ~pins_o.dq;
      #62 pins_o.sclk = 1'b1;
      rx = q ? {rx[27:0], dq_i} : {rx[30:0], dq_i[1]};
      #63 pins_o.sclk = 1'b0;
    end
    #62 pins_o.cs_n = 1'b1;
    pins_o.dq = ~pins_o.dq;
    // Gap well over four system clocks lets the effect settle
    #100;
  endtask : frame
endmodule : sfc_host_model

// >>> tb/sfc_decoder_tb.sv
/*
  Self-checking bench for the setting-command decoder.
  Assumes the host model and checker files are compiled before it.
*/
`timescale 1ns/1ns
module sfc_decoder_tb;
  import sfc_pkg::*;

  typedef struct {
    bit          q;
    logic [7:0]  op;
    int          nd;
    logic [31:0] d;
    int          nr;
    logic [31:0] rx;
    logic [7:0]  adr;
    logic [31:0] exp;
  } sfc_row_t;

  logic        clk_i;
  logic        rst_i;
  sfc_pins_t   host_pins;
  sfc_pins_t   pins_i;
  logic [3:0]  dq_o;
  logic [3:0]  dq_oe_n_o;
  logic        wide_o;
  logic        susp_o;
  logic        resu_o;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [31:0] rd;
  logic [31:0] rx;
  int          n_errors;
  int          n_checks;

  ////////////////////////////////////////////////////////////////////////////
  // Ordinary cases: op 00 means no frame, only the register read
  sfc_row_t rows [37] = '{
    '{0,8'h06,0,0,0,0,REG_STATE,1}, '{0,8'h04,0,0,0,0,REG_STATE,0},
    '{0,8'h01,1,8'hff,0,0,REG_STATUS,0}, '{0,8'h06,0,0,0,0,REG_STATE,1},
    '{0,8'h01,2,16'ha53c,0,0,REG_STATUS,8'ha5},
    '{0,8'h00,0,0,0,0,REG_CONFIG,8'h3c},
    '{0,8'h05,0,0,1,8'ha5,REG_STATE,0}, '{0,8'h15,0,0,1,8'h3c,REG_STATE,0},
    '{0,8'hc5,1,8'h5a,0,0,REG_EXT_ADDR,8'h5a},
    '{0,8'hc5,2,16'h1234,0,0,REG_EXT_ADDR,8'h5a},
    '{0,8'hc8,0,0,1,8'h5a,REG_STATE,0}, '{0,8'hb7,0,0,0,0,REG_STATE,4},
    '{0,8'hb0,0,0,0,0,REG_STATE,8'h14}, '{0,8'h30,0,0,0,0,REG_STATE,4},
    '{0,8'h75,0,0,0,0,REG_STATE,8'h14}, '{0,8'h7a,0,0,0,0,REG_STATE,4},
    '{0,8'he9,0,0,0,0,REG_STATE,0}, '{0,8'hc0,1,7,0,0,REG_BURST,7},
    '{0,8'hf5,0,0,0,0,REG_STATE,0}, '{0,8'h06,0,0,0,0,REG_STATE,1},
    '{0,8'h68,0,0,0,0,REG_STATE,9},
    '{0,8'h17,4,32'h12345678,0,0,REG_BOOT,32'h12345678},
    '{0,8'h16,0,0,4,32'h12345678,REG_STATE,8},
    '{0,8'h06,0,0,0,0,REG_STATE,9}, '{0,8'h17,3,24'habcdef,0,0,REG_BOOT,32'h12345678},
    '{0,8'h06,0,0,0,0,REG_STATE,9},
    '{0,8'h18,0,0,0,0,REG_BOOT,32'hffffffff}, '{0,8'h35,0,0,0,0,REG_STATE,8'h0a},
    '{1,8'h05,0,0,1,8'ha5,REG_STATE,8'h0a}, '{1,8'h06,0,0,0,0,REG_STATE,8'h0b},
    '{1,8'h04,0,0,0,0,REG_STATE,8'h0a}, '{1,8'hb9,0,0,0,0,REG_STATE,8'h2a},
    '{1,8'h06,0,0,0,0,REG_STATE,8'h2a}, '{1,8'hab,0,0,0,0,REG_STATE,8'h0a},
    '{1,8'hc8,0,0,1,8'h5a,REG_STATE,8'h0a}, '{1,8'h68,0,0,0,0,REG_STATE,8'h0a},
    '{1,8'hf5,0,0,0,0,REG_STATE,8}};

  sfc_decoder DUT (
    .clk_i(clk_i), .rst_i(rst_i), .pins_i(pins_i), .dq_o(dq_o),
    .dq_oe_n_o(dq_oe_n_o), .addr_four_bytes_o(wide_o), .suspend_req_o(susp_o),
    .resume_req_o(resu_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
    .wb_dat_i(32'hffff_ffff), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
  );

  sfc_host_model u_host (.pins_o(host_pins), .dq_i(pins_i.dq));

  // Shared lines: the device wins wherever it enables its driver
  always_comb begin
    pins_i = host_pins;
    for (int i = 0; i < 4; i++) if (!dq_oe_n_o[i]) pins_i.dq[i] = dq_o[i];
  end

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  // Classic cycle; ack is read before this edge's updates land
  task automatic wb(input logic we, input logic [7:0] a, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    chk("wb_ack", 1, {31'h0, wb_ack_o});
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // Watchdog: the whole run needs well under 400 us
  initial begin
    #400000;
    n_errors++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0;
    n_checks = 0;
    rst_i    = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    foreach (rows[i]) begin
      if (rows[i].op !== 8'h00)
        u_host.frame(rows[i].q, rows[i].op, rows[i].nd, rows[i].d, rows[i].nr, rx);
      if (rows[i].nr > 0) chk("serial read", rows[i].rx, rx);
      wb(1'b0, rows[i].adr, rd);
      chk("register", rows[i].exp, rd);
      if (rows[i].adr == REG_STATE) begin
        chk("wide flag", {31'h0, rows[i].exp[ST_WIDE]}, {31'h0, wide_o});
        chk("suspend", {31'h0, rows[i].exp[ST_SUSPEND]}, {31'h0, susp_o});
        chk("resume", {31'h0, !rows[i].exp[ST_SUSPEND]}, {31'h0, resu_o});
      end
    end
    // Registers are read-only from the bus; unmapped places read zero
    wb(1'b1, REG_STATUS, rd);
    wb(1'b0, REG_STATUS, rd);
    chk("status after write", 32'ha5, rd);
    wb(1'b0, 8'h40, rd);
    chk("unmapped", 32'h0, rd);
    wb(1'b0, REG_EVENTS, rd);
    chk("last opcode", {24'h0, OP_QUAD_EXIT}, rd);
    // Reset in mid-run must bring the mode flags and the boot word back to their start values
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_STATE, rd);
    chk("state after reset", 32'h0, rd);
    wb(1'b0, REG_BOOT, rd);
    chk("boot after reset", BOOT_RST, rd);
    chk("enables idle", 32'hf, {28'h0, dq_oe_n_o});
    summarize();
  end
endmodule : sfc_decoder_tb
